// ---- verilog/fswc_pkg.sv ----
// Function
// R01: sweep only for sine, square, ramp carriers
// R02: sweep on turns burst and modulation off
// R03: pass start to stop, phase continuous; log offset is not cleared between internal passes
// R04: start/stop 1 mHz-10 MHz, ramp 100 kHz
// R05: direction follows start/stop ordering
// R06: marker off: sync 50% square per sweep
// R07: marker on: sync falls at marker frequency
// R08: center/span bounds alternative with limits
// R09: span sign selects sweep direction
// R10: linear or log spacing, default linear
// R11: sweep time 1 ms-500 s, steps derived
// R12: marker frequency range and default
// R13: marker clamped to nearer sweep bound
// R14: marker plus sweep overrides sync enable
// R15: triggered pass ends holding start frequency
// R16: source internal, external, manual; internal repeats
// R17: each selected external edge starts one pass
// R18: external triggers spaced sweep time plus 1 ms
// R19: manual or software trigger starts one pass
// R20: internal trigger-out 50% square, selectable edge
// R21: external source disables trigger-out
// R22: manual trigger-out single pulse over 1 us
package fswc_pkg;
  // frequencies in mHz, 34 bits reach 10 MHz = 1e10 mHz
  localparam int          FREQ_W        = 34;
  localparam logic [33:0] FREQ_MIN_MHZ  = 34'h000000001;
  localparam logic [33:0] FREQ_MAX_MHZ  = 34'h2540BE400;
  localparam logic [33:0] RAMP_MAX_MHZ  = 34'h005F5E100;
  localparam logic [33:0] START_DEF_MHZ = 34'h0000186A0;
  localparam logic [33:0] STOP_DEF_MHZ  = 34'h0000F4240;
  localparam logic [33:0] CENTER_DEF_MHZ = 34'h00008647C;
  localparam logic [33:0] SPAN_DEF_MHZ  = 34'h0000DBBA0;
  localparam logic [33:0] MARKER_DEF_MHZ = 34'h00007A120;
  // sweep time in microseconds
  localparam int          TIME_W        = 30;
  localparam logic [29:0] TIME_MIN_US   = 30'h000003E8;
  localparam logic [29:0] TIME_MAX_US   = 30'h1DCD6500;
  localparam logic [29:0] TIME_DEF_US   = 30'h000F4240;
  localparam int          CLK_HZ        = 10000000;
  localparam int          CYC_PER_US    = CLK_HZ / 1000000;
  localparam int          TRIG_PULSE_NS = 2000;
  localparam int          TRIG_PULSE_CYC = (TRIG_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          LOG_SHIFT     = 10;
  typedef enum logic [2:0] {
    FSWC_WAVE_SINE = 3'h0, FSWC_WAVE_SQUARE = 3'h1, FSWC_WAVE_RAMP = 3'h2,
    FSWC_WAVE_PULSE = 3'h3, FSWC_WAVE_NOISE = 3'h4, FSWC_WAVE_DC = 3'h5,
    FSWC_WAVE_ARB = 3'h6
  } fswc_wave_t;
  typedef enum logic [1:0] {
    FSWC_SRC_INT = 2'h0, FSWC_SRC_EXT = 2'h1, FSWC_SRC_MAN = 2'h2
  } fswc_src_t;
  typedef enum logic [1:0] {
    FSWC_ST_IDLE = 2'h0, FSWC_ST_RUN = 2'h1, FSWC_ST_DONE = 2'h3
  } fswc_state_t;
endpackage

// ---- verilog/fswc_clamp.sv ----
`timescale 1ns/1ns
module fswc_clamp
  import fswc_pkg::*;
(
  input  wire logic [FREQ_W-1:0] val,
  input  wire logic [FREQ_W-1:0] lo,
  input  wire logic [FREQ_W-1:0] hi,
  output wire logic [FREQ_W-1:0] res
);
  wire logic below;
  wire logic above;
  assign below = val < lo;
  assign above = val > hi;
  assign res   = below ? lo : (above ? hi : val);
endmodule

// ---- verilog/fswc_top.sv ----
`timescale 1ns/1ns
module fswc_top
  import fswc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cfg_load,
  input  wire logic              sweep_on,
  input  wire logic [2:0]        wave_sel,
  input  wire logic              use_center,
  input  wire logic [FREQ_W-1:0] start_mhz,
  input  wire logic [FREQ_W-1:0] stop_mhz,
  input  wire logic [FREQ_W-1:0] center_mhz,
  input  wire logic [FREQ_W-1:0] span_mhz,
  input  wire logic              span_neg,
  input  wire logic              log_sel,
  input  wire logic [TIME_W-1:0] time_us,
  input  wire logic [FREQ_W-1:0] marker_mhz,
  input  wire logic              marker_on,
  input  wire logic              sync_en,
  input  wire logic [1:0]        trig_src,
  input  wire logic              trig_slope_neg,
  input  wire logic              trig_in,
  input  wire logic              trig_manual,
  input  wire logic              trig_out_en,
  input  wire logic              trig_out_neg,
  output logic                   sweep_active,
  output logic                   burst_off,
  output logic                   mod_off,
  output logic [FREQ_W-1:0]      freq_out,
  output logic                   sync_out,
  output logic                   trig_out,
  output logic                   trig_out_oe_n,
  output logic                   cfg_ok
);
  logic [FREQ_W-1:0] start_q, stop_q, marker_q, freq_q, freq_d;
  logic [TIME_W-1:0] time_q;
  logic              log_q, marker_on_q, sync_en_q, slope_q, tout_en_q, tout_neg_q, on_q;
  logic [1:0]        src_q;
  logic [2:0]        wave_q;
  fswc_state_t       state_q, state_d;
  logic [TIME_W-1:0] us_q;
  logic [3:0]        div_q;
  logic              trig_prev_q, sync_q, tout_q, marker_hit_q;
  logic [7:0]        pulse_q;
  logic [FREQ_W+LOG_SHIFT-1:0] acc_q;

  wire logic              is_ramp;
  wire logic              wave_ok;
  wire logic [FREQ_W-1:0] fmax;
  wire logic [FREQ_W-1:0] half_span;
  wire logic [FREQ_W-1:0] cs_lo;
  wire logic [FREQ_W-1:0] cs_hi;
  wire logic [FREQ_W-1:0] raw_start;
  wire logic [FREQ_W-1:0] raw_stop;
  wire logic [FREQ_W-1:0] lim_start;
  wire logic [FREQ_W-1:0] lim_stop;
  wire logic [FREQ_W-1:0] lim_marker;
  wire logic [FREQ_W-1:0] lo_b;
  wire logic [FREQ_W-1:0] hi_b;
  wire logic [FREQ_W-1:0] mk_clamped;
  wire logic [TIME_W-1:0] lim_time;
  wire logic              going_up;
  wire logic [FREQ_W-1:0] delta;
  wire logic [FREQ_W-1:0] lin_off;
  wire logic [FREQ_W-1:0] log_off;
  wire logic [FREQ_W-1:0] off_sel;
  wire logic              us_tick;
  wire logic              pass_end;
  wire logic              edge_rise;
  wire logic              edge_fall;
  wire logic              ext_trig;
  wire logic              launch;
  wire logic              running;
  wire logic              half_done;
  wire logic              marker_reached;

  assign is_ramp = wave_sel == FSWC_WAVE_RAMP;
  assign wave_ok = (wave_sel == FSWC_WAVE_SINE) || (wave_sel == FSWC_WAVE_SQUARE) ||
                   is_ramp; // R01
  assign fmax    = is_ramp ? RAMP_MAX_MHZ : FREQ_MAX_MHZ; // R04
  assign half_span = span_mhz >> 1;
  assign cs_lo   = (center_mhz > half_span) ? center_mhz - half_span : FREQ_MIN_MHZ; // R08
  assign cs_hi   = center_mhz + half_span;
  assign raw_start = use_center ? (span_neg ? cs_hi : cs_lo) : start_mhz; // R09
  assign raw_stop  = use_center ? (span_neg ? cs_lo : cs_hi) : stop_mhz;
  assign lim_time  = (time_us < TIME_MIN_US) ? TIME_MIN_US :
                     ((time_us > TIME_MAX_US) ? TIME_MAX_US : time_us); // R11

  fswc_clamp u_cl_start (.val(raw_start), .lo(FREQ_MIN_MHZ), .hi(fmax), .res(lim_start));
  fswc_clamp u_cl_stop  (.val(raw_stop), .lo(FREQ_MIN_MHZ), .hi(fmax), .res(lim_stop));
  fswc_clamp u_cl_mark  (.val(marker_mhz), .lo(FREQ_MIN_MHZ), .hi(fmax), .res(lim_marker)); // R12
  assign lo_b = (lim_start < lim_stop) ? lim_start : lim_stop;
  assign hi_b = (lim_start < lim_stop) ? lim_stop : lim_start;
  fswc_clamp u_cl_mk2 (.val(lim_marker), .lo(lo_b), .hi(hi_b), .res(mk_clamped)); // R13

  // configuration capture
  always_ff @(posedge clk) begin
    if (rst) begin
      start_q     <= START_DEF_MHZ; // R04
      stop_q      <= STOP_DEF_MHZ;
      marker_q    <= MARKER_DEF_MHZ; // R12
      time_q      <= TIME_DEF_US; // R11
      log_q       <= 1'b0; // R10
      marker_on_q <= 1'b0;
      sync_en_q   <= 1'b1;
      src_q       <= FSWC_SRC_INT; // R16
      slope_q     <= 1'b0;
      tout_en_q   <= 1'b0;
      tout_neg_q  <= 1'b0;
      wave_q      <= FSWC_WAVE_SINE;
      on_q        <= 1'b0;
      cfg_ok      <= 1'b1;
    end else if (cfg_load) begin
      start_q     <= lim_start;
      stop_q      <= lim_stop;
      marker_q    <= sweep_on ? mk_clamped : lim_marker; // R13
      time_q      <= lim_time;
      log_q       <= log_sel; // R10
      marker_on_q <= marker_on;
      sync_en_q   <= sync_en;
      src_q       <= trig_src;
      slope_q     <= trig_slope_neg;
      tout_en_q   <= trig_out_en;
      tout_neg_q  <= trig_out_neg;
      wave_q      <= wave_sel;
      on_q        <= sweep_on && wave_ok; // R01
      cfg_ok      <= wave_ok || !sweep_on;
    end
  end

  assign sweep_active = on_q;
  assign burst_off    = on_q; // R02
  assign mod_off      = on_q; // R02

  // triggering
  assign edge_rise = trig_in && !trig_prev_q;
  assign edge_fall = !trig_in && trig_prev_q;
  assign ext_trig  = (src_q == FSWC_SRC_EXT) && (slope_q ? edge_fall : edge_rise); // R17
  assign running   = state_q == FSWC_ST_RUN;
  assign launch    = on_q && !running &&
                     ((src_q == FSWC_SRC_INT) || ext_trig ||
                      ((src_q == FSWC_SRC_MAN) && trig_manual)); // R16 R19
  assign us_tick   = div_q == 4'(CYC_PER_US - 1);
  assign pass_end  = running && us_tick && (us_q == time_q - 30'h1);
  assign half_done = us_q >= (time_q >> 1); // R06

  // a trigger arriving mid-pass is dropped; external spacing is the source's duty
  always_comb begin
    state_d = state_q;
    case (state_q)
      FSWC_ST_IDLE: if (launch) state_d = FSWC_ST_RUN;
      FSWC_ST_RUN: begin
        if (!on_q) state_d = FSWC_ST_IDLE;
        else if (pass_end) state_d = (src_q == FSWC_SRC_INT) ? FSWC_ST_RUN : FSWC_ST_DONE; // R16 R15
      end
      FSWC_ST_DONE: if (launch) state_d = FSWC_ST_RUN; // R15
      default: state_d = FSWC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= FSWC_ST_IDLE;
      trig_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      trig_prev_q <= trig_in;
    end
  end

  // elapsed time inside a pass
  always_ff @(posedge clk) begin
    if (rst || !running || pass_end) begin
      div_q <= 4'h0;
      us_q  <= 30'h0;
    end else if (us_tick) begin
      div_q <= 4'h0;
      us_q  <= us_q + 30'h1; // R11
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // frequency progression, offset from start in the sweep direction
  assign going_up = start_q <= stop_q; // R05
  assign delta    = going_up ? stop_q - start_q : start_q - stop_q;
  assign lin_off  = FREQ_W'((64'(delta) * 64'(us_q)) / 64'(time_q)); // R10
  // log: offset grows by 1/256 of itself plus a fixed step per microsecond, cleared only while not running
  assign log_off  = FREQ_W'(acc_q >> LOG_SHIFT);
  assign off_sel  = (log_q ? log_off : lin_off) > delta ? delta : (log_q ? log_off : lin_off);

  always_ff @(posedge clk) begin
    if (rst || !running) begin
      acc_q <= {FREQ_W+LOG_SHIFT{1'b0}};
    end else if (us_tick) begin
      acc_q <= (FREQ_W+LOG_SHIFT)'(acc_q + (acc_q >> 8) +
               (((FREQ_W+LOG_SHIFT)'(delta) << LOG_SHIFT) / (FREQ_W+LOG_SHIFT)'(64'(time_q) << 3)));
    end
  end

  // held frequency steps without a reset of phase; the synthesis core
  // only retunes its increment, so phase stays continuous
  // last step of a pass lands on the stop value itself
  assign freq_d = !running ? start_q : (pass_end ? stop_q :
                  (going_up ? start_q + off_sel : start_q - off_sel)); // R03 R15
  // judged on the value about to show, so a new pass never sees the old stop
  assign marker_reached = going_up ? (freq_d >= marker_q) : (freq_d <= marker_q); // R07

  always_ff @(posedge clk) begin
    if (rst) begin
      freq_q       <= START_DEF_MHZ;
      marker_hit_q <= 1'b0;
    end else begin
      freq_q       <= freq_d; // R03
      marker_hit_q <= running && !(pass_end || launch) && (marker_hit_q || marker_reached); // R07
    end
  end
  assign freq_out = freq_q;

  // sync output
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else if (!on_q) begin
      sync_q <= 1'b0;
    end else if (marker_on_q) begin
      sync_q <= running && !marker_hit_q && !marker_reached; // R07 R14
    end else begin
      sync_q <= sync_en_q && running && !half_done; // R06
    end
  end
  assign sync_out = sync_q;

  // trigger out
  always_ff @(posedge clk) begin
    if (rst) begin
      tout_q  <= 1'b0;
      pulse_q <= 8'h00;
    end else if (src_q == FSWC_SRC_MAN) begin
      if (launch) pulse_q <= 8'(TRIG_PULSE_CYC); // R22
      else if (pulse_q != 8'h00) pulse_q <= pulse_q - 8'h01;
      tout_q <= launch || (pulse_q > 8'h01);
    end else begin
      pulse_q <= 8'h00;
      tout_q  <= running && !half_done; // R20
    end
  end
  assign trig_out      = (tout_en_q && on_q && src_q != FSWC_SRC_EXT) ? (tout_q ^ tout_neg_q) :
                         tout_neg_q; // R20 R21
  assign trig_out_oe_n = !(tout_en_q && on_q && src_q != FSWC_SRC_EXT); // R21
endmodule

// ---- test/fswc_top_assertions.sv ----
`timescale 1ns/1ns
module fswc_top_chk
  import fswc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cfg_load,
  input wire logic              sweep_on,
  input wire logic [2:0]        wave_sel,
  input wire logic [1:0]        trig_src,
  input wire logic              trig_out_neg,
  input wire logic              sweep_active,
  input wire logic              burst_off,
  input wire logic              mod_off,
  input wire logic [FREQ_W-1:0] freq_out,
  input wire logic              sync_out,
  input wire logic              trig_out,
  input wire logic              trig_out_oe_n,
  input wire logic              cfg_ok
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ext_q;
  logic man_q;
  wire  ok_w = wave_sel <= 3'h2;
  wire  act  = trig_out ^ trig_out_neg;
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_q <= 1'b0;
      man_q <= 1'b0;
    end else if (cfg_load) begin
      ext_q <= trig_src == FSWC_SRC_EXT;
      man_q <= trig_src == FSWC_SRC_MAN;
    end
  end
  // pulse held past 1 us
  sequence s_pulse;
    act [*8] ##1 act [*3];
  endsequence
  a_bad_wave: assert property (cfg_load && sweep_on && !ok_w |=> !sweep_active && !cfg_ok)
    else $error("sweep taken on bad wave");
  a_good_wave: assert property (cfg_load && sweep_on && ok_w |=> sweep_active && cfg_ok)
    else $error("sweep refused on good wave");
  a_modes_off: assert property (sweep_active |-> burst_off && mod_off)
    else $error("burst or modulation left on");
  a_freq_range: assert property (sweep_active |-> freq_out >= FREQ_MIN_MHZ && freq_out <= FREQ_MAX_MHZ)
    else $error("frequency out of range");
  a_ext_no_out: assert property (ext_q && $past(ext_q) |-> trig_out_oe_n)
    else $error("trigger out driven on external source");
  a_man_pulse: assert property (man_q && $rose(act) |-> s_pulse)
    else $error("manual trigger pulse too short");
  a_reset_vals: assert property ($fell(rst) |-> freq_out == START_DEF_MHZ && cfg_ok && trig_out_oe_n)
    else $error("bad values after reset");
  a_sync_start: assert property ($rose(sync_out) |-> sweep_active)
    else $error("sync rose with sweep off");
endmodule
bind fswc_top fswc_top_chk u_chk (
  .clk(clk), .rst(rst), .cfg_load(cfg_load), .sweep_on(sweep_on), .wave_sel(wave_sel),
  .trig_src(trig_src), .trig_out_neg(trig_out_neg), .sweep_active(sweep_active),
  .burst_off(burst_off), .mod_off(mod_off), .freq_out(freq_out), .sync_out(sync_out),
  .trig_out(trig_out), .trig_out_oe_n(trig_out_oe_n), .cfg_ok(cfg_ok)
);

// ---- test/fswc_trig_src.sv ----
`timescale 1ns/1ns
module fswc_trig_src #(
  parameter int GAP = 10
) (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic neg,
  output logic      trig
);
  int gap_q = 0;
  int hi_q  = 0;
  always @(negedge clk) begin
    gap_q <= gap_q + 1;
    if (go && gap_q >= GAP) begin
      hi_q <= 4;
      gap_q <= 0;
    end else if (hi_q > 0) begin
      hi_q <= hi_q - 1;
    end
  end
  assign trig = (hi_q > 0) ^ neg;
endmodule

// ---- test/frequency_sweep_controller_tb.sv ----
`timescale 1ns/1ns
module frequency_sweep_controller_tb;
  import fswc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cfg_load, sweep_on, use_center, span_neg, log_sel, marker_on, go;
  logic              sync_en, trig_slope_neg, trig_manual, trig_out_en, trig_out_neg;
  logic [2:0]        wave_sel;
  logic [1:0]        trig_src;
  logic [TIME_W-1:0] time_us;
  logic [FREQ_W-1:0] start_mhz, stop_mhz, center_mhz, span_mhz, marker_mhz, f0, f1;
  logic              trig_in, sweep_active, burst_off, mod_off, sync_out, trig_out;
  logic              trig_out_oe_n, cfg_ok;
  logic [FREQ_W-1:0] freq_out;
  int                n_fail = 0;
  int                n_tests = 0;
  int                n;
  always #50 clk = ~clk;
  fswc_top DUT (
    .clk(clk), .rst(rst), .cfg_load(cfg_load), .sweep_on(sweep_on), .wave_sel(wave_sel),
    .use_center(use_center), .start_mhz(start_mhz), .stop_mhz(stop_mhz),
    .center_mhz(center_mhz), .span_mhz(span_mhz), .span_neg(span_neg), .log_sel(log_sel),
    .time_us(time_us), .marker_mhz(marker_mhz), .marker_on(marker_on), .sync_en(sync_en),
    .trig_src(trig_src), .trig_slope_neg(trig_slope_neg), .trig_in(trig_in),
    .trig_manual(trig_manual), .trig_out_en(trig_out_en), .trig_out_neg(trig_out_neg),
    .sweep_active(sweep_active), .burst_off(burst_off), .mod_off(mod_off),
    .freq_out(freq_out), .sync_out(sync_out), .trig_out(trig_out),
    .trig_out_oe_n(trig_out_oe_n), .cfg_ok(cfg_ok)
  );
  // spacing of sweep time plus 1 ms
  fswc_trig_src #(.GAP(2000 * CYC_PER_US)) u_src (.clk(clk), .go(go), .neg(trig_slope_neg),
    .trig(trig_in));
  task automatic finish_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [40:0] e, logic [40:0] g, logic [40:0] t = 0);
    n_tests++;
    if ($isunknown(g) || g + t < e || g > e + t) begin
      n_fail++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic ld();
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(2);
  endtask
  task automatic wsync(logic v);
    n = 0;
    while (sync_out !== v) begin
      cyc(1);
      n++;
      if (n > 30000) begin
        n_fail++;
        finish_test();
      end
    end
  endtask
  task automatic bounds();
    f0 = 34'(1000 + $urandom % 40000000);
    f1 = f0 + 34'(1000 + $urandom % 40000000);
    start_mhz = f0;
    stop_mhz = f1;
    wave_sel = 3'($urandom % 3);
  endtask
  // one pass: start value, then midpoint or marker point
  task automatic pass(logic mk, logic [FREQ_W-1:0] m);
    logic [40:0] d;
    d = f0 > f1 ? f0 - f1 : f1 - f0;
    wsync(1'b0);
    wsync(1'b1);
    chk("f_start", f0, freq_out, d / 100);
    wsync(1'b0);
    if (mk) begin
      chk("f_marker", m, freq_out, d / 50);
    end else begin
      chk("sync_half", 5000, n, 5);
      chk("f_mid", (f0 + f1) / 2, freq_out, d / 50);
    end
  endtask
  initial begin
    {cfg_load, sweep_on, use_center, span_neg, log_sel, marker_on, trig_manual, go} = '0;
    {trig_slope_neg, trig_out_neg, trig_src, wave_sel, marker_mhz} = '0;
    {sync_en, trig_out_en, center_mhz, span_mhz} = '1;
    {start_mhz, stop_mhz, time_us} = {START_DEF_MHZ, STOP_DEF_MHZ, 30'h000003E8};
    n = $urandom(32);
    cyc(12);
    rst = 1'b0;
    chk("rst_freq", START_DEF_MHZ, freq_out);
    chk("rst_ok", 1, cfg_ok);
    $display("reset done");
    sweep_on = 1'b1;
    for (int w = 6; w >= 0; w--) begin
      wave_sel = 3'(w);
      ld();
      chk("cfg_ok", w <= 2, cfg_ok);
      chk("active", w <= 2, sweep_active);
      chk("burst_mod", w <= 2 ? 2'h3 : 2'h0, {burst_off, mod_off});
    end
    $display("wave done");
    bounds();
    ld();
    chk("oe_int", 0, trig_out_oe_n);
    pass(1'b0, 0);
    wsync(1'b1);
    chk("sync_low", 5000, n, 5);
    cyc(20);
    chk("trig_hi", 1, trig_out);
    $display("internal done");
    center_mhz = 34'(20000000 + $urandom % 40000000);
    span_mhz = 34'(2000 + $urandom % 20000000);
    {f0, f1} = {center_mhz + span_mhz / 2, center_mhz - span_mhz / 2};
    {use_center, span_neg, marker_on, sync_en, marker_mhz} = {4'hE, 34'h000000001};
    ld();
    pass(1'b1, f1);
    $display("center done");
    bounds();
    {use_center, span_neg, sync_en, trig_slope_neg} = 4'h3;
    marker_mhz = f0 + (f1 - f0) / 4;
    trig_src = FSWC_SRC_EXT;
    ld();
    cyc(11000);
    chk("oe_ext", 1, trig_out_oe_n);
    chk("f_hold", f0, freq_out);
    go = 1'b1;
    pass(1'b1, marker_mhz);
    go = 1'b0;
    cyc(8000);
    chk("f_hold", f0, freq_out);
    $display("external done");
    {trig_src, marker_on} = {FSWC_SRC_MAN, 1'b0};
    ld();
    chk("oe_man", 0, trig_out_oe_n);
    trig_manual = 1'b1;
    cyc(1);
    trig_manual = 1'b0;
    pass(1'b0, 0);
    cyc(6000);
    chk("f_hold", f0, freq_out);
    $display("manual done");
    {log_sel, trig_out_neg} = 2'h3;
    ld();
    chk("tout_idle", 1, trig_out);
    trig_manual = 1'b1;
    cyc(1);
    trig_manual = 1'b0;
    chk("tout_pulse", 0, trig_out);
    wsync(1'b1);
    chk("f_log_start", f0, freq_out, (f1 - f0) / 100);
    wsync(1'b0);
    // log midpoint lies below the linear midpoint on an upward sweep
    chk("f_log_mid", f0 + (f1 - f0) / 4, freq_out, (f1 - f0) / 4);
    $display("log done");
    finish_test();
  end
endmodule
